// ===== verilog/peripheral_clock_gating.sv
// Peripheral clock gating registers, mode selection and bus fault check
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module peripheral_clock_gating (
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [11:0] address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic      [1:0]  response,
    input  wire logic        sleepReq,
    input  wire logic        deepSleepReq,
    input  wire logic [10:0] unitAccess,
    output logic      [10:0] accessFault,
    output logic             controller_area_gate,
    output logic             low_power_keeper_gate,
    output logic             watchdog_gate,
    output logic      [3:0]  gp_counter_gate,
    output logic             two_wire_gate,
    output logic             sync_serial_gate,
    output logic             async_serial1_gate,
    output logic             async_serial0_gate,
    output logic             irq
);
    // Unit index on unitAccess/accessFault:
    // 0 async0, 1 async1, 2 sync, 3 two-wire, 4..7 timers 0..3,
    // 8 watchdog, 9 keeper, 10 controller area

    // ==========================================
    // Register state
    logic [31:0] runGate0_q, sleepGate0_q, deep_sleep_clock_gate_0_q;
    logic [31:0] run_mode_clock_gate_1_q, sleep_mode_clock_gate_1_q;
    logic [31:0] deep_sleep_clock_gate_1_q;
    logic        auto_gating_select_q;
    logic [10:0] faultStat_q, faultMask_q;
    logic        ack_q;
    logic [31:0] readdata_q;
    logic [1:0]  response_q;
    logic        sleepMeta_q, sleepSync_q, deepMeta_q, deepSync_q;
    logic [10:0] accessFault_q;
    logic [31:0] gate0Act, gate1Act;
    logic [10:0] unitEn;
    logic [31:0] byteMask;
    logic        wrStb, rdStb;
    clock_gate_pkg::power_mode_t mode;

    assign byteMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                       {8{byteenable[1]}}, {8{byteenable[0]}}};
    // One wait state: writes land on the accepting edge, reads are fetched one edge early
    assign wrStb = write && ack_q;
    assign rdStb = read && !ack_q;
    assign waitrequest = (read || write) && !ack_q;

    // Bus acknowledge toggles off after each answered beat
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (read || write) && !ack_q;
        end
    end

    // ==========================================
    // Gate registers; reserved bits never store
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            runGate0_q                <= clock_gate_pkg::GATE0_RESET;
            sleepGate0_q              <= clock_gate_pkg::GATE0_RESET;
            deep_sleep_clock_gate_0_q <= clock_gate_pkg::GATE0_RESET;
            run_mode_clock_gate_1_q   <= clock_gate_pkg::GATE1_RESET;
            sleep_mode_clock_gate_1_q <= clock_gate_pkg::GATE1_RESET;
            deep_sleep_clock_gate_1_q <= clock_gate_pkg::GATE1_RESET;
        end else if (wrStb) begin
            unique case (address)
                clock_gate_pkg::RUN_GATE0_OFS:
                    runGate0_q <= wrMerge(runGate0_q, clock_gate_pkg::GATE0_MASK);
                clock_gate_pkg::SLEEP_GATE0_OFS:
                    sleepGate0_q <= wrMerge(sleepGate0_q, clock_gate_pkg::GATE0_MASK);
                clock_gate_pkg::DEEP_GATE0_OFS:
                    deep_sleep_clock_gate_0_q <= wrMerge(deep_sleep_clock_gate_0_q,
                                                         clock_gate_pkg::GATE0_MASK);
                clock_gate_pkg::RUN_GATE1_OFS:
                    run_mode_clock_gate_1_q <= wrMerge(run_mode_clock_gate_1_q,
                                                       clock_gate_pkg::GATE1_MASK);
                clock_gate_pkg::SLEEP_GATE1_OFS:
                    sleep_mode_clock_gate_1_q <= wrMerge(sleep_mode_clock_gate_1_q,
                                                         clock_gate_pkg::GATE1_MASK);
                clock_gate_pkg::DEEP_GATE1_OFS:
                    deep_sleep_clock_gate_1_q <= wrMerge(deep_sleep_clock_gate_1_q,
                                                         clock_gate_pkg::GATE1_MASK);
                default: ;
            endcase
        end
    end

    // Masked byte-lane merge of write data
    function automatic logic [31:0] wrMerge(input logic [31:0] old,
                                            input logic [31:0] msk);
        logic [31:0] m;
        m = byteMask & msk;
        wrMerge = (old & ~m) | (writedata & m);
    endfunction

    // Auto-gating select and interrupt mask
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            auto_gating_select_q <= 1'b0;
            faultMask_q          <= 11'h000;
        end else if (wrStb && address == clock_gate_pkg::MODE_CTRL_OFS && byteenable[0]) begin
            auto_gating_select_q <= writedata[clock_gate_pkg::AUTO_BIT];
        end else if (wrStb && address == clock_gate_pkg::FAULT_MASK_OFS) begin
            faultMask_q <= writedata[10:0];
        end
    end

    // ==========================================
    // Low-power requests come from outside: two-stage synchronisers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sleepMeta_q <= 1'b0;
            sleepSync_q <= 1'b0;
            deepMeta_q  <= 1'b0;
            deepSync_q  <= 1'b0;
        end else begin
            sleepMeta_q <= sleepReq;
            sleepSync_q <= sleepMeta_q;
            deepMeta_q  <= deepSleepReq;
            deepSync_q  <= deepMeta_q;
        end
    end

    // Mode choice; deep sleep wins over sleep
    always_comb begin
        if (!auto_gating_select_q) begin
            mode = clock_gate_pkg::MODE_RUN;
        end else if (deepSync_q) begin
            mode = clock_gate_pkg::MODE_DEEP;
        end else if (sleepSync_q) begin
            mode = clock_gate_pkg::MODE_SLEEP;
        end else begin
            mode = clock_gate_pkg::MODE_RUN;
        end
    end

    // Active gate set for the present mode
    always_comb begin
        unique case (mode)
            clock_gate_pkg::MODE_SLEEP: begin
                gate0Act = sleepGate0_q;
                gate1Act = sleep_mode_clock_gate_1_q;
            end
            clock_gate_pkg::MODE_DEEP: begin
                gate0Act = deep_sleep_clock_gate_0_q;
                gate1Act = deep_sleep_clock_gate_1_q;
            end
            default: begin
                gate0Act = runGate0_q;
                gate1Act = run_mode_clock_gate_1_q;
            end
        endcase
    end

    // Per-unit clock enables
    assign unitEn = {gate0Act[clock_gate_pkg::CAN_BIT],
                     gate0Act[clock_gate_pkg::KEEP_BIT],
                     gate0Act[clock_gate_pkg::WDOG_BIT],
                     gate1Act[clock_gate_pkg::TMR_LO +: 4],
                     gate1Act[clock_gate_pkg::TWI_BIT],
                     gate1Act[clock_gate_pkg::SSI_BIT],
                     gate1Act[clock_gate_pkg::ASER1_BIT],
                     gate1Act[clock_gate_pkg::ASER0_BIT]};
    assign controller_area_gate  = unitEn[10];
    assign low_power_keeper_gate = unitEn[9];
    assign watchdog_gate         = unitEn[8];
    assign gp_counter_gate       = unitEn[7:4];
    assign two_wire_gate         = unitEn[3];
    assign sync_serial_gate      = unitEn[2];
    assign async_serial1_gate    = unitEn[1];
    assign async_serial0_gate    = unitEn[0];

    // ==========================================
    // Fault on access to an unclocked unit, registered one cycle later and held as long as the access lasts
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            accessFault_q <= 11'h000;
        end else begin
            accessFault_q <= unitAccess & ~unitEn;
        end
    end
    assign accessFault = accessFault_q;

    // Sticky status; a new fault wins over a write-one clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            faultStat_q <= 11'h000;
        end else begin
            faultStat_q <= (faultStat_q & ~((wrStb && address == clock_gate_pkg::FAULT_STAT_OFS)
                           ? writedata[10:0] : 11'h000)) | accessFault_q;
        end
    end
    assign irq = |(faultStat_q & faultMask_q);

    // ==========================================
    // Read data and response; unmapped gives SLAVEERROR
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata_q <= 32'h0000_0000;
            response_q <= 2'h0;
        end else if (rdStb || (write && !ack_q)) begin
            response_q <= 2'h0;
            readdata_q <= 32'h0000_0000;
            unique case (address)
                clock_gate_pkg::RUN_GATE0_OFS:   readdata_q <= rdStb ? runGate0_q : 32'h0;
                clock_gate_pkg::SLEEP_GATE0_OFS: readdata_q <= rdStb ? sleepGate0_q : 32'h0;
                clock_gate_pkg::DEEP_GATE0_OFS:
                    readdata_q <= rdStb ? deep_sleep_clock_gate_0_q : 32'h0;
                clock_gate_pkg::RUN_GATE1_OFS:
                    readdata_q <= rdStb ? run_mode_clock_gate_1_q : 32'h0;
                clock_gate_pkg::SLEEP_GATE1_OFS:
                    readdata_q <= rdStb ? sleep_mode_clock_gate_1_q : 32'h0;
                clock_gate_pkg::DEEP_GATE1_OFS:
                    readdata_q <= rdStb ? deep_sleep_clock_gate_1_q : 32'h0;
                clock_gate_pkg::MODE_CTRL_OFS:
                    readdata_q <= rdStb ? {31'h0, auto_gating_select_q} : 32'h0;
                clock_gate_pkg::FAULT_STAT_OFS:
                    readdata_q <= rdStb ? {21'h0, faultStat_q} : 32'h0;
                clock_gate_pkg::FAULT_MASK_OFS:
                    readdata_q <= rdStb ? {21'h0, faultMask_q} : 32'h0;
                default: response_q <= 2'h2;
            endcase
        end
    end
    assign readdata = readdata_q;
    assign response = response_q;

    // ==========================================
    // Checks
    a_deep_reset_val: assert property (@(posedge core_clk)
        $rose(arst_n) |-> deep_sleep_clock_gate_0_q == 32'h0000_0040)
        else $error("deep gate 0 reset wrong");
    a_run_reset_val: assert property (@(posedge core_clk)
        $rose(arst_n) |-> run_mode_clock_gate_1_q == 32'h0)
        else $error("run gate 1 reset wrong");
    a_gate0_reserved: assert property (@(posedge core_clk) disable iff (!arst_n)
        (deep_sleep_clock_gate_0_q & 32'hFEFF_FFB7) == 32'h0)
        else $error("deep gate 0 reserved set");
    a_gate1_reserved: assert property (@(posedge core_clk) disable iff (!arst_n)
        (run_mode_clock_gate_1_q & 32'hFFF0_EFEC) == 32'h0)
        else $error("run gate 1 reserved set");
    a_fault_unclk: assert property (@(posedge core_clk) disable iff (!arst_n)
        (unitAccess[8] && !watchdog_gate) |=> accessFault[8])
        else $error("watchdog fault missing");
    a_fault_clocked: assert property (@(posedge core_clk) disable iff (!arst_n)
        (unitAccess[0] && async_serial0_gate) |=> !accessFault[0])
        else $error("spurious fault");
    a_no_auto_run: assert property (@(posedge core_clk) disable iff (!arst_n)
        !auto_gating_select_q |-> gp_counter_gate == run_mode_clock_gate_1_q[19:16])
        else $error("run set not applied");
    a_deep_select: assert property (@(posedge core_clk) disable iff (!arst_n)
        (auto_gating_select_q && deepSync_q) |-> controller_area_gate ==
        deep_sleep_clock_gate_0_q[24])
        else $error("deep set not applied");
    a_sleep_select: assert property (@(posedge core_clk) disable iff (!arst_n)
        (auto_gating_select_q && sleepSync_q && !deepSync_q) |->
        two_wire_gate == sleep_mode_clock_gate_1_q[12])
        else $error("sleep set not applied");
    a_write_lands: assert property (@(posedge core_clk) disable iff (!arst_n)
        (write && !waitrequest && address == 12'h104 && byteenable == 4'hF) |=>
        run_mode_clock_gate_1_q == ($past(writedata) & 32'h000F_1013))
        else $error("run gate write lost");

    // ==========================================
    // Further checks on gating, faults and the bus
    // Exactly one wait state per request
    a_wait_one: assert property (@(posedge core_clk) disable iff (!arst_n)
        ((read || write) && waitrequest) |=> !waitrequest)
        else $error("wait state count wrong");

    // Latched faults stay until cleared
    a_fault_sticky: assert property (@(posedge core_clk) disable iff (!arst_n)
        !(wrStb && address == clock_gate_pkg::FAULT_STAT_OFS) |=>
        ((faultStat_q & $past(faultStat_q)) == $past(faultStat_q)))
        else $error("fault status lost");

    // Every fault pulse lands in the status
    a_fault_latch: assert property (@(posedge core_clk) disable iff (!arst_n)
        (accessFault_q != 11'h000) |=>
        ((faultStat_q & $past(accessFault_q)) == $past(accessFault_q)))
        else $error("fault not latched");

    // Keeper gate follows the run set
    a_keep_run: assert property (@(posedge core_clk) disable iff (!arst_n)
        !auto_gating_select_q |-> low_power_keeper_gate == runGate0_q[6])
        else $error("keeper gate wrong");

    // Controller area gate follows the run set
    a_can_run: assert property (@(posedge core_clk) disable iff (!arst_n)
        !auto_gating_select_q |-> controller_area_gate == runGate0_q[24])
        else $error("controller area gate wrong");

    // Watchdog gate follows the run set
    a_wdog_run: assert property (@(posedge core_clk) disable iff (!arst_n)
        !auto_gating_select_q |-> watchdog_gate == runGate0_q[3])
        else $error("watchdog gate wrong");

    // Two-wire gate follows the run set
    a_twi_run: assert property (@(posedge core_clk) disable iff (!arst_n)
        !auto_gating_select_q |-> two_wire_gate == run_mode_clock_gate_1_q[12])
        else $error("two-wire gate wrong");

    // Synchronous serial gate follows the run set
    a_ssi_run: assert property (@(posedge core_clk) disable iff (!arst_n)
        !auto_gating_select_q |-> sync_serial_gate == run_mode_clock_gate_1_q[4])
        else $error("sync serial gate wrong");

    // Asynchronous serial gates follow the run set
    a_aser_run: assert property (@(posedge core_clk) disable iff (!arst_n)
        !auto_gating_select_q |->
        {async_serial1_gate, async_serial0_gate} == run_mode_clock_gate_1_q[1:0])
        else $error("async serial gates wrong");

    // Clocked watchdog never faults
    a_wdog_clocked: assert property (@(posedge core_clk) disable iff (!arst_n)
        (unitAccess[8] && watchdog_gate) |=> !accessFault[8])
        else $error("spurious watchdog fault");

    // Sleep register 1 reserved bits stay clear
    a_sleep_reserved: assert property (@(posedge core_clk) disable iff (!arst_n)
        (sleep_mode_clock_gate_1_q & ~clock_gate_pkg::GATE1_MASK) == 32'h0000_0000)
        else $error("sleep gate 1 reserved set");

    // Deep sleep applies the deep keeper bit
    a_deep_keeper: assert property (@(posedge core_clk) disable iff (!arst_n)
        (auto_gating_select_q && deepSync_q) |->
        low_power_keeper_gate == deep_sleep_clock_gate_0_q[6])
        else $error("deep keeper gate wrong");

    // Unmapped writes leave run register 1 unchanged
    a_unmapped_keep: assert property (@(posedge core_clk) disable iff (!arst_n)
        (wrStb && address == 12'h200) |=> $stable(run_mode_clock_gate_1_q))
        else $error("unmapped write landed");
endmodule

// ===== verilog/clock_gate_pkg.sv
// Constants for the peripheral clock gating block
// Notes on behaviour
// - Deep-sleep register 0 bit 24 gates the CAN-style unit; resets clear.
// - Deep-sleep register 0 bit 6 gates the low-power keeper; resets set.
// - Deep-sleep register 0 bit 3 gates the watchdog; unclocked access faults.
// - Reserved bits of deep-sleep register 0 are read-only zero.
// - Run register 1 decodes at offset 0x104 and resets to zero.
// - Each gate bit drives one clock enable for its unit.
// - Bus access to an unclocked unit ends in a bus fault.
// - Gate bits reset to zero except keeper bit 6 of every register 0; software enables what it uses.
// - Run set applies when running, sleep set in sleep, deep set in deep sleep.
// - Sleep and deep-sleep sets apply only while auto-gating select is set.
// - Run register 1 bits 19 to 16 gate timers 3 to 0.
// - Run register 1 bit 12 gates the two-wire serial unit.
// - Run register 1 bit 4 gates the synchronous serial unit.
// - Run register 1 bits 1 and 0 gate asynchronous serial units 1 and 0.
// - Reserved bits of run register 1 read zero and ignore writes.
// - Deep-sleep register 0 sits at 0x120 and resets to 0x00000040.
// - Sleep register 1 sits at 0x114, resets zero, same layout as run.
package clock_gate_pkg;
    // ==========================================
    // Register byte offsets within the block
    localparam logic [11:0] RUN_GATE1_OFS   = 12'h104;
    localparam logic [11:0] SLEEP_GATE1_OFS = 12'h114;
    localparam logic [11:0] DEEP_GATE1_OFS  = 12'h124;
    localparam logic [11:0] DEEP_GATE0_OFS  = 12'h120;
    localparam logic [11:0] RUN_GATE0_OFS   = 12'h100;
    localparam logic [11:0] SLEEP_GATE0_OFS = 12'h110;
    localparam logic [11:0] MODE_CTRL_OFS   = 12'h060;
    localparam logic [11:0] FAULT_STAT_OFS  = 12'h180;
    localparam logic [11:0] FAULT_MASK_OFS  = 12'h184;
    // ==========================================
    // Writable bit masks
    localparam logic [31:0] GATE0_MASK  = 32'h0100_0048;
    localparam logic [31:0] GATE1_MASK  = 32'h000F_1013;
    // ==========================================
    // Reset values
    localparam logic [31:0] GATE0_RESET = 32'h0000_0040;
    localparam logic [31:0] GATE1_RESET = 32'h0000_0000;
    // ==========================================
    // Field positions
    localparam int CAN_BIT   = 24;
    localparam int KEEP_BIT  = 6;
    localparam int WDOG_BIT  = 3;
    localparam int TMR_LO    = 16;
    localparam int TWI_BIT   = 12;
    localparam int SSI_BIT   = 4;
    localparam int ASER1_BIT = 1;
    localparam int ASER0_BIT = 0;
    localparam int AUTO_BIT  = 0;
    // Peripheral index on the target select
    localparam int NUM_UNITS = 11;
    // Power modes
    typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} power_mode_t;
endpackage

// ===== verification/peripheral_clock_gating_tb.sv
// Self-checking bench for the peripheral clock gating block
`timescale 1ns/100ps
module peripheral_clock_gating_tb;
    logic        core_clk     = 1'b0;
    logic        arst_n       = 1'b0;
    logic [11:0] address      = 12'h000;
    logic        read         = 1'b0;
    logic        write        = 1'b0;
    logic [31:0] writedata    = 32'h0000_0000;
    logic [3:0]  byteenable   = 4'hF;
    logic        sleepReq     = 1'b0;
    logic        deepSleepReq = 1'b0;
    logic [10:0] unitAccess   = 11'h000;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
    logic [10:0] accessFault;
    logic        controller_area_gate, low_power_keeper_gate, watchdog_gate;
    logic [3:0]  gp_counter_gate;
    logic        two_wire_gate, sync_serial_gate, async_serial1_gate, async_serial0_gate;
    logic        irq;
    logic [31:0] mreg [logic [11:0]];
    logic [11:0] ofs [6] = '{12'h104, 12'h114, 12'h124, 12'h100, 12'h110, 12'h120};
    logic [31:0] rd, dat;
    logic [1:0]  rsp;
    logic [10:0] ua, stat;
    int          fails    = 0;
    int          cmpCount = 0;
    int          seed     = 32'h3fabe4b9;
    // Clock of 50 MHz
    always #10 core_clk = ~core_clk;
    peripheral_clock_gating i_peripheral_clock_gating (
        .core_clk(core_clk), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .response(response),
        .sleepReq(sleepReq), .deepSleepReq(deepSleepReq), .unitAccess(unitAccess),
        .accessFault(accessFault), .controller_area_gate(controller_area_gate),
        .low_power_keeper_gate(low_power_keeper_gate), .watchdog_gate(watchdog_gate),
        .gp_counter_gate(gp_counter_gate), .two_wire_gate(two_wire_gate),
        .sync_serial_gate(sync_serial_gate), .async_serial1_gate(async_serial1_gate),
        .async_serial0_gate(async_serial0_gate), .irq(irq));
    // ==========================================
    // Model and helpers
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        cmpCount++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    function automatic logic [31:0] wmask(input logic [11:0] a);
        if (a == 12'h100 || a == 12'h110 || a == 12'h120) return 32'h0100_0048;
        if (a == 12'h184) return 32'h0000_07FF;
        if (a == 12'h060) return 32'h0000_0001;
        return 32'h000F_1013;
    endfunction
    // Enable vector in unit index order, picked by the power mode
    function automatic logic [10:0] expGates();
        logic [11:0] o0, o1;
        o0 = 12'h100;
        o1 = 12'h104;
        if (mreg[12'h060][0] && deepSleepReq) begin
            o0 = 12'h120;
            o1 = 12'h124;
        end else if (mreg[12'h060][0] && sleepReq) begin
            o0 = 12'h110;
            o1 = 12'h114;
        end
        return {mreg[o0][24], mreg[o0][6], mreg[o0][3], mreg[o1][19:16], mreg[o1][12],
                mreg[o1][4], mreg[o1][1], mreg[o1][0]};
    endfunction
    function automatic logic [10:0] seenGates();
        return {controller_area_gate, low_power_keeper_gate, watchdog_gate, gp_counter_gate,
                two_wire_gate, sync_serial_gate, async_serial1_gate, async_serial0_gate};
    endfunction
    task automatic doReset();
        arst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        foreach (ofs[i]) mreg[ofs[i]] = (i > 2) ? 32'h0000_0040 : 32'h0000_0000;
        mreg[12'h060] = 32'h0;
        mreg[12'h184] = 32'h0;
        stat = 11'h000;
    endtask
    // Avalon request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        logic [31:0] lm;
        lm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        read       <= ~wr;
        write      <= wr;
        @(posedge core_clk);
        while (waitrequest !== 1'b0) @(posedge core_clk);
        rd  = readdata;
        rsp = response;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge core_clk);
        if (wr && a == 12'h180) stat = stat & ~d[10:0];
        else if (wr && mreg.exists(a))
            mreg[a] = ((mreg[a] & ~lm) | (d & lm)) & wmask(a);
    endtask
    // ==========================================
    // Main sequence
    initial begin
        doReset();
        @(posedge core_clk);
        check("gates after reset", {21'h0, expGates()}, {21'h0, seenGates()});
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0, 4'hF);
            check("reset value", mreg[ofs[i]], rd);
        end
        foreach (ofs[i]) begin
            bus(1'b1, ofs[i], 32'hFFFF_FFFF, 4'hF);
            bus(1'b0, ofs[i], 32'h0, 4'hF);
            check("reserved read", mreg[ofs[i]], rd);
            check("mapped response", 32'h0, {30'h0, rsp});
        end
        @(posedge core_clk);
        check("all run gates", {21'h0, expGates()}, {21'h0, seenGates()});
        for (int k = 0; k < 24; k++) begin
            dat = $random(seed);
            bus(1'b1, ofs[k % 6], dat, 4'(($random(seed) & 32'hE) | (k & 1)));
            bus(1'b0, ofs[k % 6], 32'h0, 4'hF);
            check("random gate word", mreg[ofs[k % 6]], rd);
            @(posedge core_clk);
            check("run gates", {21'h0, expGates()}, {21'h0, seenGates()});
        end
        bus(1'b1, 12'h200, 32'hFFFF_FFFF, 4'hF);
        check("unmapped write response", 32'h2, {30'h0, rsp});
        bus(1'b0, 12'h200, 32'h0, 4'hF);
        check("unmapped read response", 32'h2, {30'h0, rsp});
        // Every power mode with auto-gating select off and on
        for (int a = 0; a < 2; a++) begin
            bus(1'b1, 12'h060, 32'(a), 4'h1);
            for (int m = 0; m < 3; m++) begin
                sleepReq     <= (m == 1);
                deepSleepReq <= (m == 2);
                repeat (5) @(posedge core_clk);
                check("mode gates", {21'h0, expGates()}, {21'h0, seenGates()});
            end
        end
        sleepReq     <= 1'b0;
        deepSleepReq <= 1'b0;
        repeat (5) @(posedge core_clk);
        // Accesses to unclocked units fault and latch in the status
        for (int k = 0; k < 8; k++) begin
            ua = 11'($random(seed));
            unitAccess <= ua;
            repeat (2) @(posedge core_clk);
            check("access fault", {21'h0, ua & ~expGates()}, {21'h0, accessFault});
            stat = stat | (ua & ~expGates());
            unitAccess <= 11'h000;
            @(posedge core_clk);
        end
        bus(1'b0, 12'h180, 32'h0, 4'hF);
        check("fault status", {21'h0, stat}, rd);
        @(posedge core_clk);
        check("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, 12'h184, 32'h0000_07FF, 4'hF);
        @(posedge core_clk);
        check("irq unmasked", {31'h0, stat != 11'h000}, {31'h0, irq});
        bus(1'b1, 12'h180, 32'h0000_07FF, 4'hF);
        bus(1'b0, 12'h180, 32'h0, 4'hF);
        check("fault status cleared", 32'h0, rd);
        @(posedge core_clk);
        check("irq cleared", 32'h0, {31'h0, irq});
        // Second reset in mid-run restores defaults
        doReset();
        bus(1'b0, 12'h120, 32'h0, 4'hF);
        check("deep gate0 after reset", 32'h0000_0040, rd);
        stop_test();
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        stop_test();
    end
endmodule
